// [hw/rsc_cfg.svh]
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// --------------------
// Register port layout
// --------------------
`define RSC_ADDR_W 8
`define RSC_DATA_W 8
`define RSC_OFF_CTRL 8'h00
`define RSC_OFF_OSC 8'h04
`define RSC_OFF_STAT 8'h08
`define RSC_OFF_WAKE 8'h0c

// --------------------
// Field positions
// --------------------
`define RSC_CTRL_REQ_LO 0
`define RSC_CTRL_REQ_HI 1
`define RSC_REQ_NONE 2'h0
`define RSC_REQ_PAUSE 2'h1
`define RSC_REQ_DEEP 2'h2
`define RSC_REQ_XTAL 2'h3
`define RSC_OSC_CF 0
`define RSC_OSC_XTAL 1
`define RSC_OSC_MRC 2
`define RSC_OSC_FVRC 3
`define RSC_OSC_LRC 4
`define RSC_OSC_XSEL 5
`define RSC_WAKE_E0LVL 0
`define RSC_WAKE_E1LVL 1
`define RSC_STAT_EXT 4
`define RSC_STAT_LVD 5
`define RSC_STAT_WDT 6
`define RSC_STAT_POR 7

// --------------------
// Reset values and levels
// --------------------
`define RSC_OSC_RST 8'h1c
`define RSC_WAKE_RST 8'h00
`define RSC_POR_LEVELS 8
`define RSC_LVD_LEVELS 7
`define RSC_LEVEL_W 3
`define RSC_LVD_TOP 3'h6

`endif

// [hw/rsc_pkg.sv]
package rsc_pkg;

   // Standby mode state
   typedef enum logic [2:0] {
      RSC_RUN,
      RSC_PAUSE,
      RSC_DEEP,
      RSC_XTAL,
      RSC_WAKE
   } rsc_mode_t;

   // Oscillator run enables
   typedef struct packed {
      logic cf;
      logic xtal;
      logic mrc;
      logic fvrc;
      logic lrc;
   } rsc_osc_t;

   // Wake source requests from the interrupt logic
   typedef struct packed {
      logic anyIrq;
      logic extZero;
      logic extOne;
      logic extTwo;
      logic extFour;
      logic port0;
      logic baseTimer;
   } rsc_wake_t;

   // Option straps
   typedef struct packed {
      logic [2:0] porLevel;
      logic lvdUse;
      logic [2:0] lvdLevel;
   } rsc_opt_t;

endpackage

// [hw/rsc_sync.sv]
`timescale 1ns/100ps

// Three-stage synchroniser; output moves once stages two and three agree
module rsc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk, // System clock
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic [W-1:0] async, // Raw inputs from outside
   output logic [W-1:0] sync // Filtered synchronous copy
);

   logic [W-1:0] stageOne; // First stage, read only by stage two
   logic [W-1:0] stageTwo; // Second stage
   logic [W-1:0] stageThree; // Third stage

   // --------------------
   // Shift chain
   // --------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stageOne <= INIT;
         stageTwo <= INIT;
         stageThree <= INIT;
      end else begin
         stageOne <= async;
         stageTwo <= stageOne;
         stageThree <= stageTwo;
      end
   end

   // Accept a bit only when the last two stages match
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync <= INIT;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (stageTwo[i] == stageThree[i]) begin
               sync[i] <= stageThree[i];
            end
         end
      end
   end

endmodule // rsc_sync

// [hw/rsc_top.sv]
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "rsc_cfg.svh"

// Notes on behaviour
// - Power-up reset only at first power-on
// - Power-up release at one of eight strapped levels
// - Supply-drop and power-up both raise system reset
// - Straps enable supply-drop, pick one of seven
// - Pause: core stops, peripherals keep running
// - Pause leaves oscillators as they are
// - Pause ends on pin, drop, watchdog, interrupt
// - Deep stop halts core and all peripherals
// - Deep stop kills ceramic, RC and crystal oscillators
// - Watchdog setting owns low-speed RC in stop
// - Deep stop ends on resets, ext irqs, port0
// - Ext irq zero/one wake only in level mode
// - Crystal stop keeps only base timer running
// - Crystal stop kills ceramic/RC, crystal kept
// - Crystal stop adds base-timer wake if crystal selected
// - System reset stops ceramic and crystal oscillators
module rsc_top (
   input wire logic clk, // System clock, 100 MHz
   input wire logic reset_n, // Digital power-on reset, active low
   input wire logic [`RSC_ADDR_W-1:0] regAddr, // Register address
   input wire logic [`RSC_DATA_W-1:0] regWdata, // Register write data
   input wire logic regWr, // Write strobe
   input wire logic regRd, // Read strobe
   output logic [`RSC_DATA_W-1:0] regRdata, // Read data, cycle after strobe
   input wire logic externalResetPin_n, // Reset pin, active low, async
   input wire logic [`RSC_POR_LEVELS-1:0] porAbove, // Supply above each release level
   input wire logic [`RSC_LVD_LEVELS-1:0] lvdAbove, // Supply above each drop level
   input wire rsc_pkg::rsc_opt_t optStrap, // Option configuration straps
   input wire logic wdtReset, // Watchdog reset request
   input wire logic wdtLowRcKeep, // Watchdog standby low-speed RC setting
   input wire rsc_pkg::rsc_wake_t wakeReq, // Interrupt requests
   output logic sysReset_n, // System reset to the chip, active low
   output logic cpuRun, // Instruction execution allowed
   output logic periphRun, // Peripheral clocks allowed
   output logic baseTimerRun, // Base timer clock allowed
   output rsc_pkg::rsc_osc_t oscEn, // Oscillator run enables
   output logic irqResume // Pulse: interrupt exit, service it
);

   // --------------------
   // Declarations
   // --------------------
   logic pinSync; // Synchronised reset pin level
   logic [`RSC_POR_LEVELS-1:0] porSync; // Synchronised release compares
   logic [`RSC_LVD_LEVELS-1:0] lvdSync; // Synchronised drop compares
   rsc_pkg::rsc_opt_t opt; // Straps caught after reset release
   logic optCaught; // Straps have been caught
   logic porDone; // Power-up reset has released
   logic lvdTrip; // Supply below drop threshold
   logic resetNow; // Any system reset cause this cycle
   rsc_pkg::rsc_mode_t mode; // Standby state
   rsc_pkg::rsc_mode_t next_mode; // Next standby state
   logic [`RSC_DATA_W-1:0] oscReg; // Software oscillator enables
   logic [`RSC_DATA_W-1:0] wakeCfg; // Detection mode of ext irqs
   logic [2:0] causeFlags; // Sticky reset causes
   logic xtalKept; // Crystal state at crystal-stop entry
   logic pauseWake; // Pause exit by interrupt
   logic deepWake; // Deep stop exit by interrupt
   logic xtalWake; // Crystal stop exit by interrupt
   logic ctrlWrite; // Write to control register
   logic statWrite; // Write to status register
   logic [1:0] standbyReq; // Requested standby code

   // Is this strobe aimed at that offset
   function automatic logic hit(input logic strobe, input logic [`RSC_ADDR_W-1:0] a,
                                input logic [`RSC_ADDR_W-1:0] off);
      hit = strobe && (a == off);
   endfunction

   // --------------------
   // Input synchronisers
   // --------------------
   rsc_sync #(.W(1), .INIT(1'b1)) u_pin_sync (
      .clk(clk),
      .reset_n(reset_n),
      .async(externalResetPin_n),
      .sync(pinSync)
   );

   rsc_sync #(.W(`RSC_POR_LEVELS + `RSC_LVD_LEVELS), .INIT('0)) u_lvl_sync (
      .clk(clk),
      .reset_n(reset_n),
      .async({porAbove, lvdAbove}),
      .sync({porSync, lvdSync})
   );

   // --------------------
   // Option straps
   // --------------------
   // Caught once after release; fixed for the rest of power-on
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         opt <= '0;
         optCaught <= 1'b0;
      end else if (!optCaught) begin
         opt <= optStrap;
         optCaught <= 1'b1;
      end
   end

   // --------------------
   // Power-up and supply-drop resets
   // --------------------
   // Power-up release latches; nothing but power-on clears it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         porDone <= 1'b0;
      end else if (optCaught && porSync[opt.porLevel]) begin
         porDone <= 1'b1;
      end
   end

   // Supply-drop compare, only when strapped in; top code clamps
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lvdTrip <= 1'b0;
      end else if (optCaught && opt.lvdUse) begin
         if (opt.lvdLevel > `RSC_LVD_TOP) begin
            lvdTrip <= !lvdSync[`RSC_LVD_TOP];
         end else begin
            lvdTrip <= !lvdSync[opt.lvdLevel];
         end
      end else begin
         lvdTrip <= 1'b0;
      end
   end

   assign resetNow = !porDone || lvdTrip || !pinSync || wdtReset;

   // System reset output
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sysReset_n <= 1'b0;
      end else begin
         sysReset_n <= !resetNow;
      end
   end

   // Sticky causes; a new cause beats a software clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         causeFlags <= 3'h0;
      end else begin
         causeFlags <= (statWrite ? causeFlags & ~regWdata[`RSC_STAT_WDT:`RSC_STAT_EXT]
                                  : causeFlags) | {wdtReset, lvdTrip, !pinSync};
      end
   end

   // --------------------
   // Register writes
   // --------------------
   assign ctrlWrite = hit(regWr, regAddr, `RSC_OFF_CTRL);
   assign statWrite = hit(regWr, regAddr, `RSC_OFF_STAT);
   assign standbyReq = regWdata[`RSC_CTRL_REQ_HI:`RSC_CTRL_REQ_LO];

   // Oscillator register; system reset stops ceramic and crystal
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         oscReg <= `RSC_OSC_RST;
      end else if (resetNow) begin
         oscReg <= `RSC_OSC_RST;
      end else if (hit(regWr, regAddr, `RSC_OFF_OSC)) begin
         oscReg <= regWdata;
      end
   end

   // Ext irq detection modes, as set in the interrupt block
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wakeCfg <= `RSC_WAKE_RST;
      end else if (resetNow) begin
         wakeCfg <= `RSC_WAKE_RST;
      end else if (hit(regWr, regAddr, `RSC_OFF_WAKE)) begin
         wakeCfg <= regWdata;
      end
   end

   // --------------------
   // Wake decode
   // --------------------
   assign pauseWake = wakeReq.anyIrq;
   assign deepWake = (wakeReq.extZero && wakeCfg[`RSC_WAKE_E0LVL])
                  || (wakeReq.extOne && wakeCfg[`RSC_WAKE_E1LVL])
                  || wakeReq.extTwo || wakeReq.extFour || wakeReq.port0;
   assign xtalWake = deepWake
                  || (wakeReq.baseTimer && oscReg[`RSC_OSC_XSEL]);

   // --------------------
   // Standby state machine
   // --------------------
   always_comb begin
      next_mode = mode;
      unique case (mode)
         rsc_pkg::RSC_RUN: begin
            if (ctrlWrite) begin
               unique case (standbyReq)
                  `RSC_REQ_PAUSE: next_mode = rsc_pkg::RSC_PAUSE;
                  `RSC_REQ_DEEP: next_mode = rsc_pkg::RSC_DEEP;
                  `RSC_REQ_XTAL: next_mode = rsc_pkg::RSC_XTAL;
                  `RSC_REQ_NONE: next_mode = rsc_pkg::RSC_RUN;
               endcase
            end
         end
         rsc_pkg::RSC_PAUSE: begin
            if (pauseWake) begin
               next_mode = rsc_pkg::RSC_WAKE;
            end
         end
         rsc_pkg::RSC_DEEP: begin
            if (deepWake) begin
               next_mode = rsc_pkg::RSC_WAKE;
            end
         end
         rsc_pkg::RSC_XTAL: begin
            if (xtalWake) begin
               next_mode = rsc_pkg::RSC_WAKE;
            end
         end
         rsc_pkg::RSC_WAKE: begin
            next_mode = rsc_pkg::RSC_RUN;
         end
         default: begin
            next_mode = rsc_pkg::RSC_RUN;
         end
      endcase
   end

   // State register; any reset cause ends standby at once
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode <= rsc_pkg::RSC_RUN;
      end else if (resetNow) begin
         mode <= rsc_pkg::RSC_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   // Crystal state captured on crystal-stop entry
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         xtalKept <= 1'b0;
      end else if (mode == rsc_pkg::RSC_RUN && next_mode == rsc_pkg::RSC_XTAL) begin
         xtalKept <= oscReg[`RSC_OSC_XTAL];
      end
   end

   // --------------------
   // Execution and peripheral gating
   // --------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cpuRun <= 1'b0;
         periphRun <= 1'b0;
         baseTimerRun <= 1'b0;
      end else if (resetNow) begin
         cpuRun <= 1'b0;
         periphRun <= 1'b0;
         baseTimerRun <= 1'b0;
      end else begin
         unique case (next_mode)
            rsc_pkg::RSC_PAUSE: begin
               cpuRun <= 1'b0;
               periphRun <= 1'b1;
               baseTimerRun <= 1'b1;
            end
            rsc_pkg::RSC_DEEP: begin
               cpuRun <= 1'b0;
               periphRun <= 1'b0;
               baseTimerRun <= 1'b0;
            end
            rsc_pkg::RSC_XTAL: begin
               cpuRun <= 1'b0;
               periphRun <= 1'b0;
               baseTimerRun <= 1'b1;
            end
            rsc_pkg::RSC_RUN, rsc_pkg::RSC_WAKE: begin
               cpuRun <= 1'b1;
               periphRun <= 1'b1;
               baseTimerRun <= 1'b1;
            end
            default: begin
               cpuRun <= 1'b1;
               periphRun <= 1'b1;
               baseTimerRun <= 1'b1;
            end
         endcase
      end
   end

   // --------------------
   // Oscillator gating
   // --------------------
   // Software enables pass in run and pause; stops override them
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         oscEn <= '0;
      end else if (resetNow) begin
         oscEn.cf <= 1'b0;
         oscEn.xtal <= 1'b0;
         oscEn.mrc <= 1'((`RSC_OSC_RST >> `RSC_OSC_MRC) & 8'h01);
         oscEn.fvrc <= 1'((`RSC_OSC_RST >> `RSC_OSC_FVRC) & 8'h01);
         oscEn.lrc <= 1'((`RSC_OSC_RST >> `RSC_OSC_LRC) & 8'h01);
      end else begin
         unique case (next_mode)
            rsc_pkg::RSC_DEEP: begin
               oscEn.cf <= 1'b0;
               oscEn.xtal <= 1'b0;
               oscEn.mrc <= 1'b0;
               oscEn.fvrc <= 1'b0;
               oscEn.lrc <= wdtLowRcKeep;
            end
            rsc_pkg::RSC_XTAL: begin
               oscEn.cf <= 1'b0;
               oscEn.xtal <= (mode == rsc_pkg::RSC_XTAL) ? xtalKept
                                                          : oscReg[`RSC_OSC_XTAL];
               oscEn.mrc <= 1'b0;
               oscEn.fvrc <= 1'b0;
               oscEn.lrc <= wdtLowRcKeep;
            end
            rsc_pkg::RSC_RUN, rsc_pkg::RSC_PAUSE, rsc_pkg::RSC_WAKE: begin
               oscEn.cf <= oscReg[`RSC_OSC_CF];
               oscEn.xtal <= oscReg[`RSC_OSC_XTAL];
               oscEn.mrc <= oscReg[`RSC_OSC_MRC];
               oscEn.fvrc <= oscReg[`RSC_OSC_FVRC];
               oscEn.lrc <= oscReg[`RSC_OSC_LRC];
            end
            default: begin
               oscEn <= '0;
            end
         endcase
      end
   end

   // --------------------
   // Resume pulse
   // --------------------
   // One cycle as the core restarts to take the waking interrupt
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irqResume <= 1'b0;
      end else begin
         irqResume <= !resetNow && (next_mode == rsc_pkg::RSC_WAKE);
      end
   end

   // --------------------
   // Register reads
   // --------------------
   // Data valid only in the cycle after the read strobe
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdata <= '0;
      end else if (!regRd) begin
         regRdata <= '0;
      end else begin
         unique case (regAddr)
            `RSC_OFF_CTRL: regRdata <= '0;
            `RSC_OFF_OSC: regRdata <= oscReg;
            `RSC_OFF_STAT: regRdata <= {porDone, causeFlags, 1'b0, mode};
            `RSC_OFF_WAKE: regRdata <= wakeCfg;
            default: regRdata <= '0;
         endcase
      end
   end

endmodule // rsc_top

// [verification/rsc_far_model.sv]
`timescale 1ns/100ps

// --------------------
// Supply comparators and interrupt sources beside the sequencer
// --------------------
module rsc_far_model #(
   parameter int POR_MV [8] = '{1670, 1970, 2070, 2370, 2570, 2870, 3860, 4350}, // Release mV
   parameter int LVD_MV [7] = '{1910, 2010, 2310, 2510, 2810, 3790, 4280} // Drop mV
) (
   input wire logic [12:0] vddMv, // Supply in millivolts
   input wire logic [5:0] src, // Sources, ext zero on top, base timer at bit 0
   output logic [7:0] porAbove, // Supply above each release level
   output logic [6:0] lvdAbove, // Supply above each drop level
   output rsc_pkg::rsc_wake_t wakeReq // Requests with summary bit on top
);
   // Comparator ladders follow the supply at once
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         porAbove[i] = int'(vddMv) >= POR_MV[i];
      end
      for (int i = 0; i < 7; i++) begin
         lvdAbove[i] = int'(vddMv) >= LVD_MV[i];
      end
   end

   // Any raised source also raises the summary request
   assign wakeReq = {|src, src};
endmodule // rsc_far_model

// [verification/rsc_top_assertions.sv]
`timescale 1ns/100ps
`include "rsc_cfg.svh"

// --------------------
// Port watcher for the reset and standby sequencer
// --------------------
module rsc_top_assertions (
   input wire logic clk, // System clock
   input wire logic reset_n, // Power-on reset, active low
   input wire logic [`RSC_LVD_LEVELS-1:0] lvdAbove, // Drop comparators
   input wire rsc_pkg::rsc_opt_t optStrap, // Option straps
   input wire logic wdtReset, // Watchdog request
   input wire logic wdtLowRcKeep, // Watchdog low RC setting
   input wire logic sysReset_n, // System reset out
   input wire logic cpuRun, // Core enable
   input wire logic periphRun, // Peripheral enable
   input wire logic baseTimerRun, // Base timer enable
   input wire rsc_pkg::rsc_osc_t oscEn, // Oscillator enables
   input wire logic irqResume // Resume pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Enabled drop level undershot by the supply
   logic dropNow;
   assign dropNow = optStrap.lvdUse && optStrap.lvdLevel != 3'h7 && !lvdAbove[optStrap.lvdLevel];

   // --------------------
   // Standby shapes
   // --------------------
   deep_core_off_a: assert property (sysReset_n && !periphRun |-> !cpuRun)
      else $error("core runs with peripherals stopped");
   deep_osc_off_a: assert property (sysReset_n && !periphRun && !baseTimerRun
      |-> !oscEn.cf && !oscEn.xtal && !oscEn.mrc && !oscEn.fvrc)
      else $error("oscillator left running in deep stop");
   stop_lrc_wdt_a: assert property (sysReset_n && !cpuRun && !periphRun
      |-> oscEn.lrc == $past(wdtLowRcKeep))
      else $error("low RC not following watchdog setting");
   pause_keeps_all_a: assert property (sysReset_n && !cpuRun && periphRun
      |-> baseTimerRun && $stable(oscEn))
      else $error("pause disturbed peripherals or oscillators");
   xtal_keeps_a: assert property (sysReset_n && !cpuRun && !periphRun && baseTimerRun
      |-> !oscEn.cf && !oscEn.mrc && !oscEn.fvrc && $stable(oscEn.xtal))
      else $error("crystal stop oscillator state wrong");

   // --------------------
   // Exits and resets
   // --------------------
   resume_pulse_a: assert property (irqResume |-> cpuRun && periphRun ##1 !irqResume)
      else $error("resume pulse shape wrong");
   resume_cause_a: assert property (irqResume |-> $past(sysReset_n) && !$past(cpuRun))
      else $error("resume without standby");
   wdt_reset_a: assert property (wdtReset |-> ##[1:2] !sysReset_n)
      else $error("watchdog request gave no system reset");
   drop_reset_a: assert property (dropNow [*8] |-> !sysReset_n)
      else $error("supply drop gave no system reset");
   reset_quiet_a: assert property (!sysReset_n
      |-> !cpuRun && !irqResume && !oscEn.cf && !oscEn.xtal)
      else $error("activity during system reset");

   // Main scenarios reached
   pause_c: cover property (sysReset_n && !cpuRun && periphRun);
   deep_c: cover property (sysReset_n && !periphRun && !baseTimerRun);
   xtal_c: cover property (sysReset_n && !periphRun && baseTimerRun);
   resume_c: cover property (irqResume);
endmodule // rsc_top_assertions

bind rsc_top rsc_top_assertions chk (.clk, .reset_n, .lvdAbove, .optStrap, .wdtReset,
   .wdtLowRcKeep, .sysReset_n, .cpuRun, .periphRun, .baseTimerRun, .oscEn, .irqResume);

// [verification/test_reset_and_standby_control.sv]
`timescale 1ns/100ps
`include "rsc_cfg.svh"

module test_reset_and_standby_control;
   // --------------------
   // Stimulus and observed signals
   // --------------------
   logic clk = 1'b0; // System clock
   logic reset_n = 1'b0; // Power-on reset
   logic [7:0] regAddr = 8'h00; // Register address
   logic [7:0] regWdata = 8'h00; // Write data
   logic regWr = 1'b0; // Write strobe
   logic regRd = 1'b0; // Read strobe
   logic extPin_n = 1'b1; // Reset pin level
   rsc_pkg::rsc_opt_t optStrap = '0; // Option straps
   logic wdtReset = 1'b0; // Watchdog request
   logic wdtLowRcKeep = 1'b0; // Watchdog low RC setting
   logic [5:0] src = 6'h00; // Interrupt sources
   logic [12:0] vdd = 13'h0; // Supply in millivolts
   logic [7:0] regRdata; // Read data
   logic [7:0] porAbove; // Release comparators
   logic [6:0] lvdAbove; // Drop comparators
   rsc_pkg::rsc_wake_t wakeReq; // Wake requests
   logic sysReset_n; // System reset out
   logic cpuRun; // Core enable
   logic periphRun; // Peripheral enable
   logic baseTimerRun; // Base timer enable
   logic irqResume; // Resume pulse
   rsc_pkg::rsc_osc_t oscEn; // Oscillator enables
   logic [7:0] expQ[$]; // Pending read results
   logic rdSeen = 1'b0; // Read taken last edge
   int nErrors = 0; // Mismatches
   int checkCount = 0; // Comparisons
   int resumes = 0; // Resume pulses seen
   int cycles = 0; // Run length
   int m; // Standby mode code
   logic [7:0] osc; // Oscillator register image
   logic [2:0] pl; // Release level strap
   logic [2:0] ll; // Drop level strap

   always #5 clk = ~clk;

   rsc_top DUT (.clk, .reset_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .externalResetPin_n(extPin_n), .porAbove, .lvdAbove, .optStrap, .wdtReset,
      .wdtLowRcKeep, .wakeReq, .sysReset_n, .cpuRun, .periphRun, .baseTimerRun, .oscEn,
      .irqResume);
   rsc_far_model far (.vddMv(vdd), .src, .porAbove, .lvdAbove, .wakeReq);

   // --------------------
   // Helpers
   // --------------------
   task automatic give_verdict();
      if (nErrors == 0 && checkCount > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      checkCount++;
      if (seen !== exp) begin
         nErrors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One-cycle write, then an idle edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask

   // One-cycle read; the watcher compares the data
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
   endtask

   // Control outputs compared mid-cycle
   task automatic see(input string nm, input logic [8:0] e);
      @(negedge clk);
      chk(nm, {sysReset_n, cpuRun, periphRun, baseTimerRun, oscEn}, e);
      @(posedge clk);
   endtask

   function automatic logic pick(input logic sel);
      return sel ? irqResume : sysReset_n;
   endfunction

   // Bounded wait for reset out or resume pulse
   task automatic waitHi(input logic sel, input logic v);
      int n;
      @(negedge clk);
      for (n = 0; n < 60 && pick(sel) !== v; n++) @(negedge clk);
      chk("wait", {8'h00, pick(sel)}, {8'h00, v});
      @(posedge clk);
   endtask

   function automatic rsc_pkg::rsc_osc_t oscOf(input logic [7:0] r);
      return {r[`RSC_OSC_CF], r[`RSC_OSC_XTAL], r[`RSC_OSC_MRC], r[`RSC_OSC_FVRC],
         r[`RSC_OSC_LRC]};
   endfunction

   // Expected outputs per mode: run, pause, deep, crystal
   function automatic logic [8:0] modeOuts(input int md);
      case (md)
         1: return {4'b1011, oscOf(osc)};
         2: return {4'b1000, 4'h0, wdtLowRcKeep};
         3: return {4'b1001, 1'b0, osc[`RSC_OSC_XTAL], 2'b00, wdtLowRcKeep};
         default: return {4'b1111, oscOf(osc)};
      endcase
   endfunction

   // Power up below the strapped release level, then above it
   task automatic powerUp(input logic useDrop);
      reset_n <= 1'b0;
      vdd <= 13'(far.POR_MV[pl] - 1);
      optStrap <= '{porLevel: pl, lvdUse: useDrop, lvdLevel: ll};
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (20) @(posedge clk);
      see("below release", 9'h007);
      vdd <= 13'd5000;
      waitHi(1'b0, 1'b1);
      osc = `RSC_OSC_RST;
      see("after power up", modeOuts(0));
   endtask

   // --------------------
   // Read watcher, resume counter and hang limit
   // --------------------
   always @(posedge clk) begin
      cycles++;
      rdSeen <= regRd;
      if (rdSeen) chk("read", {1'b0, regRdata}, {1'b0, expQ.pop_front()});
      if (irqResume === 1'b1) resumes++;
      if (cycles == 20000) begin
         nErrors++;
         give_verdict();
      end
   end

   // --------------------
   // Main sequence
   // --------------------
   initial begin
      void'($urandom(32'h82e0e201));
      pl = 3'($urandom % 8);
      ll = 3'($urandom % 7);
      powerUp(1'b1);
      wr(`RSC_OFF_STAT, 8'h70);
      rd(`RSC_OFF_STAT, 8'h80);
      rd(`RSC_OFF_OSC, `RSC_OSC_RST);
      rd(8'h44, 8'h00);
      wr(`RSC_OFF_WAKE, 8'h03);
      rd(`RSC_OFF_WAKE, 8'h03);
      osc = 8'($urandom % 32) | 8'h20;
      wr(`RSC_OFF_OSC, osc);
      // Every wake source in its mode: pause, five deep, base timer
      for (int i = 0; i < 7; i++) begin
         m = i == 0 ? 1 : i == 6 ? 3 : 2;
         wdtLowRcKeep <= 1'($urandom % 2);
         wr(`RSC_OFF_CTRL, 8'(m));
         see("enter", modeOuts(m));
         src <= 6'h01 << (i == 0 ? 0 : 6 - i);
         waitHi(1'b1, 1'b1);
         src <= 6'h00;
         see("resume", modeOuts(0));
      end
      // Edge-mode external inputs must not wake deep stop
      wr(`RSC_OFF_WAKE, 8'h00);
      wr(`RSC_OFF_CTRL, 8'h02);
      src <= 6'h30;
      repeat (10) @(posedge clk);
      see("edge no wake", modeOuts(2));
      src <= 6'h08;
      waitHi(1'b1, 1'b1);
      src <= 6'h00;
      // Base timer without crystal select, then pin reset exit
      osc = osc & 8'h1f;
      wr(`RSC_OFF_OSC, osc);
      wr(`RSC_OFF_CTRL, 8'h03);
      src <= 6'h01;
      repeat (10) @(posedge clk);
      see("no timer wake", modeOuts(3));
      extPin_n <= 1'b0;
      src <= 6'h00;
      waitHi(1'b0, 1'b0);
      extPin_n <= 1'b1;
      waitHi(1'b0, 1'b1);
      rd(`RSC_OFF_OSC, `RSC_OSC_RST);
      rd(`RSC_OFF_STAT, 8'h90);
      // Watchdog ends pause, supply drop ends deep stop
      osc = `RSC_OSC_RST;
      wr(`RSC_OFF_CTRL, 8'h01);
      wdtReset <= 1'b1;
      waitHi(1'b0, 1'b0);
      wdtReset <= 1'b0;
      waitHi(1'b0, 1'b1);
      rd(`RSC_OFF_STAT, 8'hd0);
      wr(`RSC_OFF_CTRL, 8'h02);
      vdd <= 13'(far.LVD_MV[ll] - 1);
      waitHi(1'b0, 1'b0);
      repeat (4) @(posedge clk);
      vdd <= 13'd5000;
      waitHi(1'b0, 1'b1);
      rd(`RSC_OFF_STAT, 8'hf0);
      see("after drop", modeOuts(0));
      // Drop detector unused by strap
      powerUp(1'b0);
      vdd <= 13'd1000;
      repeat (20) @(posedge clk);
      see("drop unused", modeOuts(0));
      chk("resumes", 9'(resumes), 9'd8);
      give_verdict();
   end
endmodule // test_reset_and_standby_control
